// file: hdl/ldcm_pkg.sv
// constants and types for the load driver and contact monitor
package ldcm_pkg;
  // clock rate and timing figures
  localparam int CLK_MHZ        = 250;
  localparam int OC_FILT_US     = 60;
  localparam int OC_STRONG_US   = 120;
  localparam int OCR_OFF_US     = 400;
  localparam int STATIC_FILT_US = 64;
  localparam int CYC_FILT_US    = 16;
  localparam int SETTLE_LONG_US = 800;
  localparam int SETTLE_SHORT_US = 80;
  localparam int OC_FILT_CYC    = OC_FILT_US * CLK_MHZ;
  localparam int OC_STRONG_CYC  = OC_STRONG_US * CLK_MHZ;
  localparam int OCR_OFF_CYC    = OCR_OFF_US * CLK_MHZ;
  localparam int STATIC_FILT_CYC = STATIC_FILT_US * CLK_MHZ;
  localparam int CYC_FILT_CYC   = CYC_FILT_US * CLK_MHZ;
  localparam int SETTLE_LONG_CYC = SETTLE_LONG_US * CLK_MHZ;
  localparam int SETTLE_SHORT_CYC = SETTLE_SHORT_US * CLK_MHZ;
  // register offsets
  localparam logic [3:0] ADR_SWCFG  = 4'h0;
  localparam logic [3:0] ADR_CTRL   = 4'h1;
  localparam logic [3:0] ADR_DUTY0  = 4'h2;
  localparam logic [3:0] ADR_WUCFG  = 4'h8;
  localparam logic [3:0] ADR_STAT   = 4'h9;
  localparam logic [3:0] ADR_CLRSTA = 4'ha;
  // ctrl field positions
  localparam int CTRL_LOWOHM = 0;
  localparam int CTRL_DETACH = 1;
  localparam int CTRL_OCR    = 2;
  localparam int CTRL_INHOFF = 3;
  localparam logic [31:0] RST_VAL = 32'h0;
  // switch behaviour codes
  localparam logic [1:0] SW_OFF = 2'h0;
  localparam logic [1:0] SW_ON  = 2'h1;
  localparam logic [1:0] SW_PER = 2'h2;
  localparam logic [1:0] SW_PWM = 2'h3;
  // device operating modes
  typedef enum logic [2:0] {
    MODE_INIT, MODE_NORMAL, MODE_STANDBY, MODE_SLEEP, MODE_FSLEEP
  } ldcm_mode_e;
endpackage : ldcm_pkg

// file: hdl/ldcm_top.sv
// load switches, supply enable and contact monitor logic
// How it works
// [R1] switch one has a low-ohmic select bit, normal-ohmic by default
// [R2] supply-side switches stay off from power-up until normal mode and a write, except switch three while it follows the fail-safe signal
// [R3] each supply-side switch: off, on, periodic, or pwm, per mode limits
// [R4] periodic on slow timer uses its on window, 10 or 20 ms
// [R5] periodic on fast timer uses its on window, 100us/200us/1ms
// [R6] each supply-side switch has its own 7-bit pwm and frequency select
// [R7] settings take effect when a frame completes at chip-select rise; here only switch modes wait for it, other registers apply at once
// [R8] watchdog failure or regulator undervoltage forces all off until service, except switch three while it follows the fail-safe signal
// [R9] overcurrent beyond 60 us latches a flag and holds switch off
// [R10] underload during on time latches a flag; switch keeps running
// [R11] switch three follows fail-safe signal until detach bit is set
// [R12] high-current switch has the same four behaviours
// [R13] without recovery, 120 us overcurrent latches flag, switch off
// [R14] with recovery, no flag; switch returns 400 us after switching off
// [R15] host clears recovery enable once the load has settled
// [R16] ground-side switches: off, on or pwm, normal mode only
// [R17] supply enable on in normal mode unless force-off bit set
// [R18] supply enable ignores current limit, drops on second thermal trip
// [R19] static sense: 64 us filter, polled level, change is a wake
// [R20] cyclic sense slow timer: 800 us settle then 16 us filter
// [R21] cyclic sense fast timer: 80 or 800 us settle selectable
// [R22] cyclic sample held until next period; a change flags wake
// [R23] bias bit picks pull-down or pull-up; pull-up floats when disabled; here only outside normal mode, in normal mode the pull-up stays on
// [R24] host ties contact supply switch and monitor input to one timer
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ldcm_top
  import ldcm_pkg::*;
#(
  parameter int OC_FILT   = OC_FILT_CYC,
  parameter int OC_STRONG = OC_STRONG_CYC,
  parameter int OCR_OFF   = OCR_OFF_CYC,
  parameter int ST_FILT   = STATIC_FILT_CYC,
  parameter int CY_FILT   = CYC_FILT_CYC,
  parameter int SET_LONG  = SETTLE_LONG_CYC,
  parameter int SET_SHORT = SETTLE_SHORT_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // frame completion and device state
  input  wire logic        frame_done,
  input  wire ldcm_mode_e  dev_mode,
  input  wire logic        wd_fail,
  input  wire logic        wd_ok,
  input  wire logic        reg_uv,
  input  wire logic        thermal_second,
  input  wire logic        fail_safe_signal,
  // timer windows from the shared timers
  input  wire logic        slow_on_win,
  input  wire logic        fast_on_win,
  input  wire logic        slow_period,
  input  wire logic        fast_period,
  input  wire logic [2:0]  pwm_tick,
  // load sensing, index 4 is the high-current switch, 5..6 ground side
  input  wire logic [6:0]  overcurrent,
  input  wire logic [4:0]  underload,
  input  wire logic [2:0]  contact_inputs,
  // drives
  output logic      [3:0]  supply_side_switches,
  output logic             high_current_switch,
  output logic      [1:0]  ground_side_switches,
  output logic             low_ohmic_sel,
  output logic             external_supply_enable,
  output logic      [2:0]  pull_up_en,
  output logic      [2:0]  pull_down_en,
  output logic      [2:0]  contact_wake
);
  typedef struct packed {
    logic [13:0] sw_cfg;   // 2-bit mode per switch, 5 supply + 2 ground
    logic [6:0]  sw_tsel;  // timer pick per switch for periodic mode
    logic [3:0]  ctrl;
    logic [48:0] duty;     // 7-bit duty per switch
    logic [13:0] fsel;     // 2-bit base frequency per switch
    logic [14:0] wu_cfg;   // per input: cyc, slow, sshort, dis, bias
    logic [13:0] shadow;   // pending switch modes before frame end
    logic        armed;    // settings committed at a frame end in normal mode
    logic        blocked;  // forced off until watchdog service
    logic [6:0]  oc_flag;
    logic [4:0]  ul_flag;
    logic [6:0][6:0]  pwm_cnt;
    logic [6:0][15:0] oc_cnt;
    logic [16:0] ocr_cnt;
    logic        ocr_off;
    logic [2:0][17:0] wu_cnt;
    logic [2:0]  wu_lvl;
    logic [2:0]  wu_wake;
    logic [2:0]  wu_settle;
    logic [31:0] rdata;
  } ldcm_s;
  ldcm_s q, d;

  // decode one switch mode from a packed config field
  function automatic logic [1:0] mode_of(input logic [13:0] c, input int i);
    mode_of = c[2*i +: 2];
  endfunction : mode_of

  logic normal_m;
  logic low_m;
  logic [6:0] pwm_out;
  logic [6:0] drive;
  assign normal_m = (dev_mode == MODE_NORMAL);
  assign low_m = (dev_mode == MODE_STANDBY) || (dev_mode == MODE_SLEEP);
  logic cyc_any;
  assign cyc_any = |{q.wu_cfg[14], q.wu_cfg[9], q.wu_cfg[4]};

  // per-switch pwm and drive decision, one copy per switch
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_sw
      logic [1:0] m;
      logic on_win;
      logic want;
      assign m = mode_of(q.sw_cfg, g);
      assign pwm_out[g] = (q.pwm_cnt[g] < q.duty[7*g +: 7]); // see [R6]
      assign on_win = q.sw_tsel[g] ? slow_on_win : fast_on_win; // see [R4] see [R5]
      if (g < 5) begin : g_hs
        always_comb begin
          case (m)
            SW_ON:   want = (normal_m || low_m);            // see [R3] see [R12]
            SW_PER:  want = (normal_m || low_m) && on_win;  // see [R3]
            SW_PWM:  want = (normal_m || (low_m && cyc_any)) && pwm_out[g];
            default: want = 1'b0;
          endcase
        end
      end else begin : g_ls
        always_comb begin
          case (m)
            SW_ON:   want = normal_m;                       // see [R16]
            SW_PWM:  want = normal_m && pwm_out[g];         // see [R16]
            default: want = 1'b0;
          endcase
        end
      end
      assign drive[g] = want && q.armed && !q.blocked && !q.oc_flag[g]; // see [R2] see [R8] see [R9]
    end
  endgenerate

  // outputs
  assign supply_side_switches = {drive[3],
    q.ctrl[CTRL_DETACH] ? drive[2] : (fail_safe_signal && normal_m), // see [R11]
    drive[1], drive[0]};
  assign high_current_switch = drive[4] && !q.ocr_off;               // see [R14]
  assign ground_side_switches = drive[6:5];
  assign low_ohmic_sel = q.ctrl[CTRL_LOWOHM];                        // see [R1]
  assign external_supply_enable = normal_m && !q.ctrl[CTRL_INHOFF]
                                  && !thermal_second;                // see [R17] see [R18]
  assign reg_rdata = q.rdata;
  assign contact_wake = q.wu_wake;

  // bias: disabled wake lets pull-up float outside normal mode
  generate
    for (g = 0; g < 3; g++) begin : g_bias
      assign pull_down_en[g] = !q.wu_cfg[5*g];                       // see [R23]
      assign pull_up_en[g] = q.wu_cfg[5*g] &&
                             (normal_m || !q.wu_cfg[5*g+1]);         // see [R23]
    end
  endgenerate

  // next-state logic
  always_comb begin
    logic [31:0] rd;
    logic [6:0] oc_set;
    logic tick;
    logic smp;
    rd = 32'h0;
    oc_set = 7'h0;
    tick = 1'b0;
    smp = 1'b0;
    d = q;
    // switch-mode writes land in shadow until the frame completes; other registers apply at once
    if (reg_wr) begin
      case (reg_addr)
        ADR_SWCFG: begin
          d.shadow = reg_wdata[13:0];
          d.sw_tsel = reg_wdata[20:14];
        end
        ADR_CTRL:  d.ctrl = reg_wdata[3:0];
        ADR_WUCFG: d.wu_cfg = reg_wdata[14:0];
        default: begin
          if (reg_addr >= ADR_DUTY0 && reg_addr < ADR_DUTY0 + 4'h6) begin
            // duty words share one slot for two switches beyond five
            d.duty[7*(reg_addr-ADR_DUTY0) +: 7] = reg_wdata[6:0];
            d.fsel[2*(reg_addr-ADR_DUTY0) +: 2] = reg_wdata[9:8];
            if (reg_addr == ADR_DUTY0 + 4'h5) begin
              d.duty[48:42] = reg_wdata[22:16];
              d.fsel[13:12] = reg_wdata[25:24];
            end
          end
        end
      endcase
    end
    if (frame_done && normal_m) begin
      d.sw_cfg = d.shadow;                                   // see [R7]
      d.armed = 1'b1;                                        // see [R2]
    end
    // watchdog failure or regulator undervoltage blocks drives
    if (wd_ok) d.blocked = 1'b0;
    if (wd_fail || reg_uv) d.blocked = 1'b1;                 // see [R8]
    // pwm counters run on each switch's chosen tick
    for (int i = 0; i < 7; i++) begin
      tick = pwm_tick[q.fsel[2*i +: 2] == 2'h0 ? 0 :
                      (q.fsel[2*i +: 2] == 2'h1 ? 1 : 2)];
      if (tick) d.pwm_cnt[i] = (q.pwm_cnt[i] == 7'h7e) ? 7'h0
                               : q.pwm_cnt[i] + 7'h1;
      // overcurrent filters
      if (overcurrent[i] && drive[i]) begin
        if (q.oc_cnt[i] != 16'hffff) d.oc_cnt[i] = q.oc_cnt[i] + 16'h1;
      end else begin
        d.oc_cnt[i] = 16'h0;
      end
      if (i != 4 && q.oc_cnt[i] >= 16'(OC_FILT - 1)) oc_set[i] = 1'b1; // see [R9]
    end
    // high-current switch: latch or auto-recover
    if (q.oc_cnt[4] >= 16'(OC_STRONG - 1) && !q.ocr_off) begin
      if (q.ctrl[CTRL_OCR]) begin
        d.ocr_off = 1'b1;                                    // see [R14]
        d.ocr_cnt = 17'h0;
        d.oc_cnt[4] = 16'h0;
      end else begin
        oc_set[4] = 1'b1;                                    // see [R13]
      end
    end
    if (q.ocr_off) begin
      d.ocr_cnt = q.ocr_cnt + 17'h1;
      if (q.ocr_cnt >= 17'(OCR_OFF - 1)) d.ocr_off = 1'b0;   // see [R14]
    end
    // underload sampled only while switched on
    for (int i = 0; i < 5; i++) begin
      if (underload[i] && drive[i]) d.ul_flag[i] = 1'b1;     // see [R10]
    end
    // read answers next cycle; status clear by read, set wins
    if (reg_rd) begin
      case (reg_addr)
        ADR_SWCFG: rd = {11'h0, q.sw_tsel, q.sw_cfg};
        ADR_CTRL:  rd = {28'h0, q.ctrl};
        ADR_WUCFG: rd = {17'h0, q.wu_cfg};
        ADR_STAT:  rd = {10'h0, q.wu_wake, q.wu_lvl, q.ul_flag, 4'h0, q.oc_flag};
        default:   rd = 32'h0;
      endcase
      if (reg_addr == ADR_STAT) begin
        d.oc_flag = 7'h0;                                    // see [R9]
        d.ul_flag = 5'h0;
        d.wu_wake = 3'h0;
      end
    end
    d.rdata = rd;
    d.oc_flag = d.oc_flag | q.oc_flag & ~(reg_rd && reg_addr == ADR_STAT
                ? 7'h7f : 7'h0) | oc_set;
    for (int i = 0; i < 5; i++) begin
      if (underload[i] && drive[i]) d.ul_flag[i] = 1'b1;
    end
    // contact inputs: static filter or cyclic settle and sample
    for (int k = 0; k < 3; k++) begin
      if (q.wu_cfg[5*k+4]) begin
        // cyclic sense
        if (q.wu_cfg[5*k+3] ? slow_period : fast_period) begin
          d.wu_settle[k] = 1'b1;                             // see [R22]
          d.wu_cnt[k] = 18'h0;
        end else if (q.wu_settle[k]) begin
          d.wu_cnt[k] = q.wu_cnt[k] + 18'h1;
          smp = (q.wu_cfg[5*k+3] || !q.wu_cfg[5*k+2])
                ? (q.wu_cnt[k] >= 18'(SET_LONG + CY_FILT - 1))   // see [R20]
                : (q.wu_cnt[k] >= 18'(SET_SHORT + CY_FILT - 1)); // see [R21]
          if (smp) begin
            d.wu_settle[k] = 1'b0;
            d.wu_lvl[k] = contact_inputs[k];
            if (contact_inputs[k] != q.wu_lvl[k] && !q.wu_cfg[5*k+1])
              d.wu_wake[k] = 1'b1;                           // see [R22]
          end
        end
      end else begin
        // static sense: level must hold the whole filter time
        if (contact_inputs[k] == q.wu_lvl[k]) begin
          d.wu_cnt[k] = 18'h0;
        end else begin
          d.wu_cnt[k] = q.wu_cnt[k] + 18'h1;
          if (q.wu_cnt[k] >= 18'(ST_FILT - 1)) begin
            d.wu_cnt[k] = 18'h0;
            d.wu_lvl[k] = contact_inputs[k];                 // see [R19]
            if (low_m && !q.wu_cfg[5*k+1]) d.wu_wake[k] = 1'b1; // see [R19]
          end
        end
      end
    end
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // a latched overcurrent keeps a switch off until read and cleared
  property p_oc_hold;
    @(posedge clk) disable iff (!rst_n)
      q.oc_flag[0] && !(reg_rd && reg_addr == ADR_STAT) |=> !drive[0];
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("oc switch on"); // see [R9]

  property p_block;
    @(posedge clk) disable iff (!rst_n) q.blocked |-> drive == 7'h0;
  endproperty
  a_block: assert property (p_block) else $error("blocked drive"); // see [R8]

  property p_arm;
    @(posedge clk) disable iff (!rst_n)
      !q.armed |-> supply_side_switches[0] == 1'b0 && !high_current_switch;
  endproperty
  a_arm: assert property (p_arm) else $error("drive before arm"); // see [R2]

  property p_ls_normal;
    @(posedge clk) disable iff (!rst_n)
      !normal_m |-> ground_side_switches == 2'h0;
  endproperty
  a_ls_normal: assert property (p_ls_normal) else $error("ls on"); // see [R16]

  property p_inh;
    @(posedge clk) disable iff (!rst_n)
      q.ctrl[CTRL_INHOFF] |-> !external_supply_enable;
  endproperty
  a_inh: assert property (p_inh) else $error("inh on"); // see [R17]

  property p_ocr_noflag;
    @(posedge clk) disable iff (!rst_n)
      clk_en && q.ctrl[CTRL_OCR] && !q.oc_flag[4] |=> !q.oc_flag[4];
  endproperty
  a_ocr_noflag: assert property (p_ocr_noflag) else $error("ocr flag"); // see [R14]

  property p_ul_keep;
    @(posedge clk) disable iff (!rst_n)
      clk_en && underload[1] && drive[1] |=> q.ul_flag[1];
  endproperty
  a_ul_keep: assert property (p_ul_keep) else $error("ul lost"); // see [R10]

  property p_fso;
    @(posedge clk) disable iff (!rst_n)
      !q.ctrl[CTRL_DETACH] |-> supply_side_switches[2] ==
                                 (fail_safe_signal && normal_m);
  endproperty
  a_fso: assert property (p_fso) else $error("fso mismatch"); // see [R11]

  // a control write reaches the resistance select on the next cycle
  property p_lowohm;
    @(posedge clk) disable iff (!rst_n)
      clk_en && reg_wr && reg_addr == ADR_CTRL |=>
        low_ohmic_sel == $past(reg_wdata[CTRL_LOWOHM]);
  endproperty
  a_lowohm: assert property (p_lowohm) else $error("ohmic select"); // see [R1]
endmodule : ldcm_top
`default_nettype wire

// file: verification/ldcm_load_model.sv
// loads and contact switches seen from the switch and sense pins
`timescale 1ns/1ps
`default_nettype none
module ldcm_load_model (
  // clock
  input  wire logic       clk,
  // drives from the block
  input  wire logic [3:0] supply_side_switches,
  input  wire logic       high_current_switch,
  input  wire logic [1:0] ground_side_switches,
  input  wire logic [2:0] pull_up_en,
  input  wire logic [2:0] pull_down_en,
  // fault and contact setup from the bench
  input  wire logic [6:0] short_mask,
  input  wire logic [4:0] open_mask,
  input  wire logic [2:0] contact_closed,
  input  wire logic [2:0] contact_lvl,
  // sensed conditions back to the block
  output logic      [6:0] overcurrent,
  output logic      [4:0] underload,
  output logic      [2:0] contact_inputs
);
  logic [6:0] drive;
  logic [2:0] float_q = 3'h5;
  assign drive = {ground_side_switches, high_current_switch,
                  supply_side_switches};
  // a short only draws current while its switch conducts
  assign overcurrent = drive & short_mask;
  // a missing load shows up only during on time
  assign underload = drive[4:0] & open_mask;
  // an unbiased open input wanders, so no settled value is implied
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end
  // open contact takes the bias level, closed contact its own level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (contact_closed[i]) begin
        contact_inputs[i] = contact_lvl[i];
      end else if (pull_up_en[i]) begin
        contact_inputs[i] = 1'b1;
      end else if (pull_down_en[i]) begin
        contact_inputs[i] = 1'b0;
      end else begin
        contact_inputs[i] = float_q[i];
      end
    end
  end
endmodule : ldcm_load_model
`default_nettype wire

// file: verification/test_load_driver_and_contact_monitor.sv
// self-checking bench for the load switches and contact monitor
`timescale 1ns/1ps
`default_nettype none
module test_load_driver_and_contact_monitor;
  import ldcm_pkg::*;
  // short counts keep the run brief
  localparam int OCF = 8;
  localparam int OCS = 12;
  localparam int OCR = 16;
  localparam int STF = 4;
  logic        clk, rst_n, reg_wr, reg_rd, frame_done, wd_fail, wd_ok;
  logic        reg_uv, thermal_second, fail_safe_signal, slow_on_win;
  logic        fast_on_win, hcs, low_ohmic_sel, ext_en, clk_en;
  logic        slow_period, fast_period;
  logic [3:0]  reg_addr, sss;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [2:0]  pwm_tick, pu, pd, contact_wake, cin, c_closed, c_lvl;
  logic [6:0]  oc, short_mask;
  logic [4:0]  ul, open_mask;
  logic [1:0]  gss;
  ldcm_mode_e  dev_mode;
  int          failures, checked, n;

  ldcm_top #(.OC_FILT(OCF), .OC_STRONG(OCS), .OCR_OFF(OCR), .ST_FILT(STF),
    .CY_FILT(4), .SET_LONG(10), .SET_SHORT(6)) dut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_done(frame_done), .dev_mode(dev_mode),
    .wd_fail(wd_fail), .wd_ok(wd_ok), .reg_uv(reg_uv),
    .thermal_second(thermal_second), .fail_safe_signal(fail_safe_signal),
    .slow_on_win(slow_on_win), .fast_on_win(fast_on_win),
    .slow_period(slow_period), .fast_period(fast_period),
    .pwm_tick(pwm_tick),
    .overcurrent(oc), .underload(ul), .contact_inputs(cin),
    .supply_side_switches(sss), .high_current_switch(hcs),
    .ground_side_switches(gss), .low_ohmic_sel(low_ohmic_sel),
    .external_supply_enable(ext_en), .pull_up_en(pu), .pull_down_en(pd),
    .contact_wake(contact_wake));

  ldcm_load_model load (.clk(clk), .supply_side_switches(sss),
    .high_current_switch(hcs), .ground_side_switches(gss),
    .pull_up_en(pu), .pull_down_en(pd), .short_mask(short_mask),
    .open_mask(open_mask), .contact_closed(c_closed),
    .contact_lvl(c_lvl), .overcurrent(oc), .underload(ul),
    .contact_inputs(cin));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // free-running pwm base ticks
  always @(posedge clk) begin
    pwm_tick <= rst_n ? pwm_tick + 3'h1 : 3'h0;
  end

  task automatic chk(input string w, input logic [31:0] g,
                     input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t %s got %h want %h", $time, w, g, e);
    end
  endtask : chk
  // compare all seven switch drives at once
  task automatic drv(input string w, input logic [6:0] e);
    chk(w, {25'h0, sss, hcs, gss}, {25'h0, e});
  endtask : drv
  task automatic gap(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : gap
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // write then close the frame so the settings commit
  task automatic cfg(input logic [3:0] a, input logic [31:0] d);
    wr(a, d);
    frame_done <= 1'b1;
    @(posedge clk);
    frame_done <= 1'b0;
    gap(2);
  endtask : cfg
  task automatic kick(input logic f, input logic u, input logic k);
    {wd_fail, reg_uv, wd_ok} <= {f, u, k};
    @(posedge clk);
    {wd_fail, reg_uv, wd_ok} <= 3'h0;
    gap(2);
  endtask : kick
  // one period pulse from the slow or fast timer
  task automatic per(input logic [1:0] p);
    {slow_period, fast_period} <= p;
    @(posedge clk);
    {slow_period, fast_period} <= 2'h0;
  endtask : per
  task automatic mode(input ldcm_mode_e m);
    dev_mode <= m;
    gap(2);
  endtask : mode
  task automatic fin(input string t);
    $display("test %s done", t);
  endtask : fin
  task automatic complete_run;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    {rst_n, reg_wr, reg_rd, frame_done, wd_fail, wd_ok, reg_uv} = 7'h0;
    {thermal_second, fail_safe_signal, slow_on_win, fast_on_win} = 4'h0;
    {clk_en, slow_period, fast_period} = 3'h4;
    {reg_addr, reg_wdata, short_mask, open_mask} = 48'h0;
    {c_closed, c_lvl} = 6'h0;
    {failures, checked, n} = '0;
    dev_mode = MODE_INIT;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    gap(1);
    drv("reset drives", 7'h00);
    chk("ohmic default", {31'h0, low_ohmic_sel}, 32'h0);
    rd(ADR_SWCFG, rv);
    chk("swcfg reset", rv, RST_VAL);
    rd(4'hf, rv);
    chk("unmapped read", rv, 32'h0);
    cfg(ADR_SWCFG, 32'h1555);
    drv("held before normal", 7'h00);
    fin("reset");
    // all switches on; third one still follows the fail-safe signal
    mode(MODE_NORMAL);
    cfg(ADR_SWCFG, 32'h1555);
    drv("normal on", 7'h5f);
    fail_safe_signal <= 1'b1;
    gap(2);
    drv("fail-safe on", 7'h7f);
    fail_safe_signal <= 1'b0;
    cfg(ADR_CTRL, 32'h3);
    drv("detached", 7'h7f);
    chk("low ohmic", {31'h0, low_ohmic_sel}, 32'h1);
    kick(1'b1, 1'b0, 1'b0);
    drv("wd fail", 7'h00);
    kick(1'b0, 1'b0, 1'b1);
    drv("wd ok", 7'h7f);
    kick(1'b0, 1'b1, 1'b0);
    drv("undervoltage", 7'h00);
    kick(1'b0, 1'b0, 1'b1);
    drv("restored", 7'h7f);
    fin("commit");
    // mode limits of switches and supply enable
    chk("inh normal", {31'h0, ext_en}, 32'h1);
    mode(MODE_STANDBY);
    drv("standby", 7'h7c);
    chk("inh standby", {31'h0, ext_en}, 32'h0);
    mode(MODE_FSLEEP);
    drv("forced sleep", 7'h00);
    mode(MODE_NORMAL);
    thermal_second <= 1'b1;
    gap(2);
    chk("inh thermal", {31'h0, ext_en}, 32'h0);
    thermal_second <= 1'b0;
    cfg(ADR_CTRL, 32'hb);
    chk("inh forced off", {31'h0, ext_en}, 32'h0);
    cfg(ADR_CTRL, 32'h3);
    fin("modes");
    // periodic: switch one on slow timer, switch two on fast timer
    cfg(ADR_SWCFG, 32'h400a);
    drv("periodic idle", 7'h00);
    slow_on_win <= 1'b1;
    gap(2);
    drv("slow window", 7'h08);
    fast_on_win <= 1'b1;
    gap(2);
    drv("fast window", 7'h18);
    {slow_on_win, fast_on_win} <= 2'h0;
    fin("periodic");
    // overcurrent on switch one and ground switch one
    cfg(ADR_SWCFG, 32'h1555);
    short_mask <= 7'h21;
    gap(OCF - 3);
    drv("oc filtering", 7'h7f);
    gap(6);
    drv("oc tripped", 7'h76);
    short_mask <= 7'h00;
    gap(4);
    drv("oc held off", 7'h76);
    rd(ADR_STAT, rv);
    chk("oc flags", rv & 32'hffff, 32'h0021);
    gap(2);
    drv("oc cleared", 7'h7f);
    open_mask <= 5'h02;
    gap(3);
    drv("underload runs", 7'h7f);
    open_mask <= 5'h00;
    rd(ADR_STAT, rv);
    chk("underload flag", rv & 32'hffff, 32'h1000);
    fin("protection");
    // strong switch without and with auto-recovery
    short_mask <= 7'h10;
    gap(OCS + 4);
    chk("strong trip", {31'h0, hcs}, 32'h0);
    short_mask <= 7'h00;
    rd(ADR_STAT, rv);
    chk("strong flag", rv & 32'hffff, 32'h0010);
    cfg(ADR_CTRL, 32'h7);
    short_mask <= 7'h10;
    n = 0;
    while (hcs !== 1'b0 && n < 200) begin
      gap(1);
      n++;
    end
    if (n == 200) begin
      failures++;
      $display("BAD %0t strong switch never tripped", $time);
      complete_run();
    end
    gap(OCR - 4);
    chk("recovery off", {31'h0, hcs}, 32'h0);
    gap(8);
    chk("recovery on", {31'h0, hcs}, 32'h1);
    short_mask <= 7'h00;
    rd(ADR_STAT, rv);
    chk("no strong flag", rv & 32'h10, 32'h0);
    cfg(ADR_CTRL, 32'h3);
    // a write while the clock enable is low must not land
    clk_en <= 1'b0;
    wr(ADR_CTRL, 32'h2);
    gap(1);
    chk("frozen", {31'h0, low_ohmic_sel}, 32'h1);
    clk_en <= 1'b1;
    fin("recovery");
    // static sense with pull-up, then a wake in standby
    cfg(ADR_WUCFG, 32'h1);
    chk("pull-up", {29'h0, pu}, 32'h1);
    gap(STF + 4);
    rd(ADR_STAT, rv);
    chk("polled level", rv & 32'h70000, 32'h10000);
    mode(MODE_STANDBY);
    c_closed <= 3'h1;
    gap(STF + 4);
    chk("wake flag", {29'h0, contact_wake}, 32'h1);
    rd(ADR_STAT, rv);
    chk("wake source", rv & 32'h380000, 32'h80000);
    c_closed <= 3'h0;
    cfg(ADR_WUCFG, 32'h3);
    chk("floating", {30'h0, pu[0], pd[0]}, 32'h0);
    cfg(ADR_WUCFG, 32'h0);
    chk("pull-down", {30'h0, pu[0], pd[0]}, 32'h1);
    fin("contacts");
    // cyclic sense: fast timer short settle, then slow timer long settle
    mode(MODE_NORMAL);
    cfg(ADR_SWCFG, 32'h4002);
    mode(MODE_STANDBY);
    {c_closed, c_lvl} <= 6'h09;
    cfg(ADR_WUCFG, 32'h15);
    per(2'h1);
    gap(12);
    rd(ADR_STAT, rv);
    c_lvl <= 3'h0;
    per(2'h1);
    gap(6);
    rd(ADR_STAT, rv);
    chk("cyclic held", rv & 32'h90000, 32'h10000);
    gap(4);
    rd(ADR_STAT, rv);
    chk("cyclic sample", rv & 32'h90000, 32'h80000);
    cfg(ADR_WUCFG, 32'h1d);
    c_lvl <= 3'h1;
    per(2'h2);
    gap(12);
    chk("slow settling", {29'h0, contact_wake}, 32'h0);
    gap(4);
    chk("slow sample", {29'h0, contact_wake}, 32'h1);
    fin("cyclic");
    // pwm on switch one in standby while cyclic sense is active
    mode(MODE_NORMAL);
    wr(ADR_DUTY0, 32'h40);
    cfg(ADR_SWCFG, 32'h3);
    mode(MODE_STANDBY);
    n = 0;
    repeat (254) begin
      gap(1);
      n += sss[0];
    end
    chk("pwm duty", n, 32'd128);
    fin("pwm");
    complete_run();
  end
endmodule : test_load_driver_and_contact_monitor
`default_nettype wire
